// ### pkg/dpm_pkg.sv
// shared constants of the dual-port mailbox/semaphore host controller
// assumes a 50 MHz aclk; pin timings are those of the slowest speed grade
package dpm_pkg;

   // ----------------------------------------------------------------
   // clock and pin timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 50;
   localparam int SYNC_LAT = 3;
   localparam int NS_PER_US = 1000;
   localparam int T_AA_NS = 25;
   localparam int T_DOE_NS = 13;
   localparam int T_PWE_NS = 22;
   // busy_from_address_delay, busy_from_select_delay: plain defaults
   localparam int T_BUSY_ADDR_NS = 20;
   localparam int T_BUSY_SEL_NS = 20;
   // semaphore_turnaround_time, semaphore_write_to_read_delay: plain defaults
   localparam int T_SEM_TURN_NS = 10;
   localparam int T_SEM_WRRD_NS = 10;

   // least times round up, never below one cycle
   function automatic int ns2cyc(input int ns);
      int c;
      c = (ns * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
      return (c < 1) ? 1 : c;
   endfunction : ns2cyc

   localparam int PWE_CYC = ns2cyc(T_PWE_NS);
   localparam int BUSY_CYC = (T_BUSY_ADDR_NS > T_BUSY_SEL_NS) ?
                             ns2cyc(T_BUSY_ADDR_NS) : ns2cyc(T_BUSY_SEL_NS);
   // select lands a cycle late; filter flop and edge race add two more
   localparam int SETTLE_CYC = BUSY_CYC + SYNC_LAT + 3;
   localparam int RD_CYC = ns2cyc(T_AA_NS) + SYNC_LAT;
   localparam int SEM_RD_CYC = ns2cyc(T_SEM_WRRD_NS + T_DOE_NS) + SYNC_LAT;
   localparam int TURN_CYC = ns2cyc(T_SEM_TURN_NS);
   localparam int CNT_W = 8;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam int AXI_AW = 8;
   localparam logic [AXI_AW-1:0] REG_CTRL = 8'h00;
   localparam logic [AXI_AW-1:0] REG_ADDR = 8'h04;
   localparam logic [AXI_AW-1:0] REG_WDATA = 8'h08;
   localparam logic [AXI_AW-1:0] REG_RDATA = 8'h0c;
   localparam logic [AXI_AW-1:0] REG_STATUS = 8'h10;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int ST_W = 8;
   localparam int ST_RUN = 0;
   localparam int ST_INT = 1;
   localparam int ST_BUSY_SEEN = 2;
   localparam int ST_OWNED = 3;
   localparam int ST_BAD = 4;
   localparam int SEM_AW = 3;

   typedef enum logic [2:0] {
      OP_MEM_RD = 3'h0,
      OP_MEM_WR = 3'h1,
      OP_SEM_RD = 3'h2,
      OP_SEM_WR = 3'h3,
      OP_SEM_ACQ = 3'h4,
      OP_MBX_POST = 3'h5,
      OP_MBX_READ = 3'h6,
      OP_NONE = 3'h7
   } dpm_op_e;

endpackage : dpm_pkg

// ### hdl/dpm_sync.sv
// three-flop pin synchroniser with agreement filter, one lane per bit
// assumes inputs asynchronous to aclk
`timescale 1ns/10ps
module dpm_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // pins and filtered result
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q
);
   import dpm_pkg::*;

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } dpm_sync_s;

   dpm_sync_s r_q;
   dpm_sync_s r_d;

   always_comb begin
      r_d = r_q;
      r_d.s1 = d_i;
      r_d.s2 = r_q.s1;
      r_d.s3 = r_q.s2;
      // a lane moves only once s2 and s3 agree; s1 feeds s2 alone
      r_d.q = (r_q.s2 & r_q.s3) | (r_q.q & (r_q.s2 | r_q.s3));
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r_q <= {4{RST_VAL}};
      end else begin
         r_q <= r_d;
      end
   end

   assign q = r_q.q;

endmodule : dpm_sync

// ### hdl/dpm_axil.sv
// axi4-lite register slave of the host controller
// assumes one outstanding write and one outstanding read per master
`timescale 1ns/10ps
module dpm_axil #(
   parameter int DW = 16
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite slave
   input wire logic [dpm_pkg::AXI_AW-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [dpm_pkg::AXI_AW-1:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // controller side
   output logic cmd_valid,
   output dpm_pkg::dpm_op_e cmd_op,
   output logic [31:0] cfg_addr,
   output logic [31:0] cfg_wdata,
   input wire logic [DW-1:0] rd_word,
   input wire logic [dpm_pkg::ST_W-1:0] status
);
   import dpm_pkg::*;

   typedef struct packed {
      logic aw_ok;
      logic [AXI_AW-1:0] aw_a;
      logic w_ok;
      logic [31:0] w_d;
      logic [3:0] w_s;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [31:0] addr;
      logic [31:0] wdat;
      logic cmd_valid;
      dpm_op_e cmd_op;
   } dpm_axil_s;

   dpm_axil_s r_q;
   dpm_axil_s r_d;

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
      logic [31:0] m;
      m = o;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            m[b*8 +: 8] = n[b*8 +: 8];
         end
      end
      return m;
   endfunction : merge

   always_comb begin
      r_d = r_q;
      r_d.cmd_valid = 1'b0;
      if (awvalid && awready) begin
         r_d.aw_ok = 1'b1;
         r_d.aw_a = awaddr;
      end
      if (wvalid && wready) begin
         r_d.w_ok = 1'b1;
         r_d.w_d = wdata;
         r_d.w_s = wstrb;
      end
      if (r_q.bvalid && bready) begin
         r_d.bvalid = 1'b0;
      end
      if (r_q.aw_ok && r_q.w_ok && !r_q.bvalid) begin
         r_d.aw_ok = 1'b0;
         r_d.w_ok = 1'b0;
         r_d.bvalid = 1'b1;
         r_d.bresp = RESP_OKAY;
         if (r_q.aw_a == REG_CTRL) begin
            // a start while an access runs is dropped; status shows run
            if (!status[ST_RUN] && r_q.w_s[0]) begin
               r_d.cmd_valid = 1'b1;
               r_d.cmd_op = dpm_op_e'(r_q.w_d[2:0]);
            end
         end else if (r_q.aw_a == REG_ADDR) begin
            r_d.addr = merge(r_q.addr, r_q.w_d, r_q.w_s);
         end else if (r_q.aw_a == REG_WDATA) begin
            r_d.wdat = merge(r_q.wdat, r_q.w_d, r_q.w_s);
         end else begin
            r_d.bresp = RESP_SLVERR;
         end
      end
      if (r_q.rvalid && rready) begin
         r_d.rvalid = 1'b0;
      end
      if (arvalid && arready) begin
         r_d.rvalid = 1'b1;
         r_d.rresp = RESP_OKAY;
         if (araddr == REG_CTRL) begin
            r_d.rdata = 32'(r_q.cmd_op);
         end else if (araddr == REG_ADDR) begin
            r_d.rdata = r_q.addr;
         end else if (araddr == REG_WDATA) begin
            r_d.rdata = r_q.wdat;
         end else if (araddr == REG_RDATA) begin
            r_d.rdata = 32'(rd_word);
         end else if (araddr == REG_STATUS) begin
            r_d.rdata = 32'(status);
         end else begin
            r_d.rdata = '0;
            r_d.rresp = RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r_q <= '{cmd_op: OP_NONE, default: '0};
      end else begin
         r_q <= r_d;
      end
   end

   assign awready = !r_q.aw_ok && !r_q.bvalid;
   assign wready = !r_q.w_ok && !r_q.bvalid;
   assign bvalid = r_q.bvalid;
   assign bresp = r_q.bresp;
   assign arready = !r_q.rvalid;
   assign rvalid = r_q.rvalid;
   assign rdata = r_q.rdata;
   assign rresp = r_q.rresp;
   assign cmd_valid = r_q.cmd_valid;
   assign cmd_op = r_q.cmd_op;
   assign cfg_addr = r_q.addr;
   assign cfg_wdata = r_q.wdat;

endmodule : dpm_axil

// ### hdl/dpm_host.sv
// host controller for one port of an asynchronous dual-port sram:
// memory, mailbox and semaphore accesses ordered over axi4-lite
// assumes the pins are wired straight to the port; busy and int are
// active low pins; the data bus is resolved outside from dq_oe_n
`timescale 1ns/10ps
module dpm_host #(
   parameter int AW = 15,
   parameter int DW = 16,
   parameter bit PORT_IS_RIGHT = 1'b0
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write
   input wire logic [dpm_pkg::AXI_AW-1:0] s_awaddr,
   input wire logic [2:0] s_awprot,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   // axi4-lite read
   input wire logic [dpm_pkg::AXI_AW-1:0] s_araddr,
   input wire logic [2:0] s_arprot,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   // sram port controls
   output logic [AW-1:0] mem_addr,
   output logic ce_n,
   output logic rw_n,
   output logic oe_n,
   output logic token_select_n,
   output logic ub_n,
   output logic lb_n,
   // sram port data, two-way
   input wire logic [DW-1:0] dq_i,
   output logic [DW-1:0] dq_o,
   output logic dq_oe_n,
   // sram port flags
   input wire logic int_n,
   input wire logic busy_n
);
   import dpm_pkg::*;

   typedef enum logic [2:0] {
      S_IDLE = 3'h0,
      S_SELECT = 3'h1,
      S_WRITE = 3'h2,
      S_RELEASE = 3'h3,
      S_GAP = 3'h4,
      S_READ = 3'h5
   } dpm_state_e;

   typedef struct packed {
      dpm_state_e st;
      logic [CNT_W-1:0] cnt;
      logic is_sem;
      logic is_wr;
      logic then_read;
      logic [AW-1:0] addr;
      logic [DW-1:0] dout;
      logic [DW-1:0] rword;
      logic ce_n;
      logic sel_n;
      logic oe_n;
      logic rw_n;
      logic drive;
      logic busy_seen;
      logic owned;
      logic bad;
   } dpm_host_s;

   // ----------------------------------------------------------------
   // mailbox words of this port and of the far port
   // ----------------------------------------------------------------
   localparam logic [AW-1:0] MBX_RIGHT = '1;
   localparam logic [AW-1:0] MBX_LEFT = {{(AW-1){1'b1}}, 1'b0};
   localparam logic [AW-1:0] MBX_OWN = PORT_IS_RIGHT ? MBX_RIGHT : MBX_LEFT;
   localparam logic [AW-1:0] MBX_FAR = PORT_IS_RIGHT ? MBX_LEFT : MBX_RIGHT;
   localparam logic [1:0] FLAG_IDLE = 2'h3;

   dpm_host_s r_q;
   dpm_host_s r_d;
   logic cmd_valid;
   dpm_op_e cmd_op;
   logic [31:0] cfg_addr;
   logic [31:0] cfg_wdata;
   logic [ST_W-1:0] status;
   logic [1:0] flags_s;
   logic [DW-1:0] dq_s;
   logic busy_act;
   logic int_act;

   // ----------------------------------------------------------------
   // register slave and pin synchronisers
   // ----------------------------------------------------------------
   dpm_axil #(
      .DW(DW)
   ) u_regs (
      .aclk(aclk),
      .aresetn(aresetn),
      .awaddr(s_awaddr),
      .awprot(s_awprot),
      .awvalid(s_awvalid),
      .awready(s_awready),
      .wdata(s_wdata),
      .wstrb(s_wstrb),
      .wvalid(s_wvalid),
      .wready(s_wready),
      .bresp(s_bresp),
      .bvalid(s_bvalid),
      .bready(s_bready),
      .araddr(s_araddr),
      .arprot(s_arprot),
      .arvalid(s_arvalid),
      .arready(s_arready),
      .rdata(s_rdata),
      .rresp(s_rresp),
      .rvalid(s_rvalid),
      .rready(s_rready),
      .cmd_valid(cmd_valid),
      .cmd_op(cmd_op),
      .cfg_addr(cfg_addr),
      .cfg_wdata(cfg_wdata),
      .rd_word(r_q.rword),
      .status(status)
   );

   // busy from master; reset idle so no stale busy stalls a write
   dpm_sync #(
      .W(2),
      .RST_VAL(FLAG_IDLE)
   ) u_sync_flags (
      .aclk(aclk),
      .aresetn(aresetn),
      .d_i({int_n, busy_n}),
      .q(flags_s)
   );

   dpm_sync #(
      .W(DW),
      .RST_VAL('0)
   ) u_sync_dq (
      .aclk(aclk),
      .aresetn(aresetn),
      .d_i(dq_i),
      .q(dq_s)
   );

   assign busy_act = !flags_s[0];
   assign int_act = !flags_s[1];

   always_comb begin
      status = '0;
      status[ST_RUN] = (r_q.st != S_IDLE);
      status[ST_INT] = int_act;
      status[ST_BUSY_SEEN] = r_q.busy_seen;
      status[ST_OWNED] = r_q.owned;
      status[ST_BAD] = r_q.bad;
   end

   // ----------------------------------------------------------------
   // access sequencer
   // ----------------------------------------------------------------
   always_comb begin
      r_d = r_q;
      case (r_q.st)
         S_IDLE: begin
            r_d.ce_n = 1'b1;
            r_d.sel_n = 1'b1;
            r_d.oe_n = 1'b1;
            r_d.rw_n = 1'b1;
            r_d.drive = 1'b0;
            if (cmd_valid) begin
               r_d.busy_seen = 1'b0;
               r_d.bad = 1'b0;
               r_d.then_read = 1'b0;
               r_d.is_sem = 1'b0;
               r_d.is_wr = 1'b0;
               r_d.addr = cfg_addr[AW-1:0];
               r_d.dout = cfg_wdata[DW-1:0];
               r_d.cnt = CNT_W'(SETTLE_CYC - 1);
               r_d.st = S_SELECT;
               case (cmd_op)
                  OP_MEM_RD: begin
                  end
                  OP_MEM_WR: begin
                     r_d.is_wr = 1'b1;
                  end
                  OP_SEM_RD, OP_SEM_WR, OP_SEM_ACQ: begin
                     r_d.addr = AW'(cfg_addr[SEM_AW-1:0]);
                     r_d.is_sem = 1'b1;
                     r_d.is_wr = (cmd_op != OP_SEM_RD);
                     if (cmd_op == OP_SEM_ACQ) begin
                        r_d.dout = '0;
                        r_d.then_read = 1'b1;
                     end else begin
                        r_d.dout = {DW{cfg_wdata[0]}};
                     end
                  end
                  OP_MBX_POST: begin
                     r_d.addr = MBX_FAR;
                     r_d.is_wr = 1'b1;
                  end
                  OP_MBX_READ: begin
                     r_d.addr = MBX_OWN;
                  end
                  default: begin
                     r_d.bad = 1'b1;
                     r_d.st = S_IDLE;
                  end
               endcase
            end
         end
         S_SELECT: begin
            r_d.ce_n = r_q.is_sem;
            r_d.sel_n = !r_q.is_sem;
            // oe and rw as for memory
            r_d.oe_n = r_q.is_wr;
            if (r_q.cnt != '0) begin
               r_d.cnt = r_q.cnt - 1'b1;
            end else if (r_q.is_wr) begin
               // hold a memory write until busy settles and clears
               if (busy_act && !r_q.is_sem) begin
                  r_d.busy_seen = 1'b1;
               end else begin
                  r_d.rw_n = 1'b0;
                  r_d.drive = 1'b1;
                  r_d.cnt = CNT_W'(PWE_CYC - 1);
                  r_d.st = S_WRITE;
               end
            end else begin
               r_d.cnt = r_q.is_sem ? CNT_W'(SEM_RD_CYC - 1) : CNT_W'(RD_CYC - 1);
               r_d.st = S_READ;
            end
         end
         S_WRITE: begin
            if (r_q.cnt != '0) begin
               r_d.cnt = r_q.cnt - 1'b1;
            end else begin
               // data held one more cycle past the rising write edge
               r_d.rw_n = 1'b1;
               r_d.st = S_RELEASE;
            end
         end
         S_RELEASE: begin
            r_d.ce_n = 1'b1;
            r_d.sel_n = 1'b1;
            r_d.drive = 1'b0;
            if (r_q.then_read) begin
               r_d.cnt = CNT_W'(TURN_CYC - 1);
               r_d.st = S_GAP;
            end else begin
               r_d.st = S_IDLE;
            end
         end
         S_GAP: begin
            if (r_q.cnt != '0) begin
               r_d.cnt = r_q.cnt - 1'b1;
            end else begin
               r_d.is_wr = 1'b0;
               r_d.then_read = 1'b0;
               r_d.cnt = '0;
               r_d.st = S_SELECT;
            end
         end
         S_READ: begin
            if (r_q.cnt != '0) begin
               r_d.cnt = r_q.cnt - 1'b1;
            end else begin
               // sample after address access, or after write-to-read plus oe delay for a semaphore
               r_d.rword = dq_s;
               // a busy read of memory or of the own mailbox is flagged
               if (busy_act && !r_q.is_sem) begin
                  r_d.busy_seen = 1'b1;
               end
               if (r_q.is_sem) begin
                  r_d.owned = !dq_s[0];
               end
               r_d.ce_n = 1'b1;
               r_d.sel_n = 1'b1;
               r_d.oe_n = 1'b1;
               r_d.st = S_IDLE;
            end
         end
         default: begin
            r_d.st = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r_q <= '{st: S_IDLE, ce_n: 1'b1, sel_n: 1'b1, oe_n: 1'b1, rw_n: 1'b1,
                  default: '0};
      end else begin
         r_q <= r_d;
      end
   end

   // ----------------------------------------------------------------
   // pin drive
   // ----------------------------------------------------------------
   assign mem_addr = r_q.addr;
   assign ce_n = r_q.ce_n;
   assign token_select_n = r_q.sel_n;
   assign oe_n = r_q.oe_n;
   assign rw_n = r_q.rw_n;
   assign ub_n = r_q.ce_n;
   assign lb_n = r_q.ce_n;
   assign dq_o = r_q.dout;
   assign dq_oe_n = !r_q.drive;

endmodule : dpm_host

// ### sim/dpm_host_chk.sv
// concurrent checks on the pins and axi side of dpm_host
// assumes it is bound to every instance of dpm_host
`timescale 1ns/10ps
module dpm_host_chk #(
   parameter int AW = 15,
   parameter int DW = 16
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite
   input wire logic s_arvalid,
   input wire logic s_arready,
   input wire logic s_rvalid,
   input wire logic s_rready,
   input wire logic [31:0] s_rdata,
   input wire logic s_bvalid,
   input wire logic s_bready,
   input wire logic [1:0] s_bresp,
   // sram port
   input wire logic [AW-1:0] mem_addr,
   input wire logic ce_n,
   input wire logic rw_n,
   input wire logic oe_n,
   input wire logic token_select_n,
   input wire logic [DW-1:0] dq_o,
   input wire logic dq_oe_n,
   input wire logic busy_n
);
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_sem_wr_end;
      $rose(rw_n) && !token_select_n;
   endsequence
   // busy seen from the start of a memory select must hold off the write
   sequence s_busy_wait;
      $fell(ce_n) ##1 (!busy_n && !ce_n)[*6];
   endsequence
   property p_sem_ce; !token_select_n |-> ce_n; endproperty
   property p_turn; s_sem_wr_end |=> token_select_n; endproperty
   property p_wr_oe; !rw_n |-> oe_n && !dq_oe_n; endproperty
   property p_settle; $fell(rw_n) |-> $past(!ce_n || !token_select_n, 4); endproperty
   property p_busy; s_busy_wait |-> rw_n; endproperty
   property p_sem_addr; !token_select_n |-> mem_addr[AW-1:3] == '0; endproperty
   property p_sem_data; !token_select_n && !dq_oe_n |-> dq_o == {DW{dq_o[0]}}; endproperty
   property p_rd_lat; s_arvalid && s_arready |=> s_rvalid; endproperty
   property p_r_hold; s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata); endproperty
   property p_b_hold; s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp); endproperty
   a_sem_ce: assert property (p_sem_ce) else $error("chip enable low in semaphore access");
   a_turn: assert property (p_turn) else $error("no deselect after semaphore write");
   a_wr_oe: assert property (p_wr_oe) else $error("write without data drive");
   a_settle: assert property (p_settle) else $error("write before busy settled");
   a_busy: assert property (p_busy) else $error("write during busy");
   a_sem_addr: assert property (p_sem_addr) else $error("semaphore high address bits set");
   a_sem_data: assert property (p_sem_data) else $error("semaphore data lines differ");
   a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
   a_r_hold: assert property (p_r_hold) else $error("read answer not held");
   a_b_hold: assert property (p_b_hold) else $error("write answer not held");
endmodule : dpm_host_chk

bind dpm_host dpm_host_chk #(.AW(AW), .DW(DW)) u_chk (.aclk, .aresetn, .s_arvalid,
   .s_arready, .s_rvalid, .s_rready, .s_rdata, .s_bvalid, .s_bready, .s_bresp, .mem_addr,
   .ce_n, .rw_n, .oe_n, .token_select_n, .dq_o, .dq_oe_n, .busy_n);

// ### sim/dpm_dev_model.sv
// behavioural model of one sram port with mailbox, busy and semaphores
// assumes the bench plays the far port through the far_ inputs
`timescale 1ns/10ps
module dpm_dev_model #(
   parameter int AW = 15,
   parameter int DW = 16
) (
   // near port
   input wire logic [AW-1:0] mem_addr,
   input wire logic ce_n,
   input wire logic rw_n,
   input wire logic oe_n,
   input wire logic token_select_n,
   input wire logic [DW-1:0] dq_o,
   output logic [DW-1:0] dq_i,
   output logic int_n,
   output logic busy_n,
   // far port
   input wire logic far_busy,
   input wire logic far_post,
   input wire logic [DW-1:0] far_data,
   input wire logic [7:0] far_req,
   output logic far_int
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   localparam int MBX_R = 2 ** AW - 1;
   logic [DW-1:0] mem [int];
   // latches apart from memory, all free, flags idle
   logic [7:0] near_req = '0, near_own = '0, far_own = '0;
   logic int_q = 1'b0;
   logic [DW-1:0] rd_q = '0, last_q = '0;
   logic drv;
   initial far_int = 1'b0;
   // master reports busy to the loser after its delay
   assign #(dpm_pkg::T_BUSY_SEL_NS) busy_n = !(far_busy && !ce_n);
   assign int_n = !int_q;
   task automatic sem_wr(input logic [2:0] i, input logic v);
      near_req[i] = !v;
      if (!v && !far_own[i]) near_own[i] = 1'b1;
      if (v && near_own[i]) begin
         near_own[i] = 1'b0;
         far_own[i] = far_req[i];
      end
   endtask : sem_wr
   always @(far_req) begin
      for (int i = 0; i < 8; i++) begin
         if (far_req[i] && !near_own[i]) far_own[i] = 1'b1;
         if (!far_req[i] && far_own[i]) begin
            far_own[i] = 1'b0;
            near_own[i] = near_req[i];
         end
      end
   end
   always @(posedge rw_n) begin
      if (!ce_n) mem[mem_addr] = dq_o;
      // post to far mailbox unless losing
      if (!ce_n && mem_addr == MBX_R && !far_busy) far_int = 1'b1;
      // low address bits and bit 0 only
      if (!token_select_n) sem_wr(mem_addr[2:0], dq_o[0]);
   end
   always @(posedge far_post) begin
      mem[MBX_R - 1] = far_data;
      int_q = 1'b1;
   end
   // read value held, own mailbox clears flag unless losing
   always @(negedge oe_n) begin
      #1;
      rd_q = token_select_n ? mem[mem_addr] : {DW{!near_own[mem_addr[2:0]]}};
      if (!ce_n && mem_addr == MBX_R - 1 && !far_busy) int_q = 1'b0;
   end
   // drive only on a selected read; released bus shows inverse
   assign drv = (!ce_n || !token_select_n) && !oe_n && rw_n;
   always @(negedge drv) last_q = rd_q;
   assign dq_i = drv ? rd_q : ~last_q;
endmodule : dpm_dev_model

// ### sim/test_dpm_host.sv
// self-checking bench of dpm_host against the sram port model
// assumes the bound checker and dpm_dev_model as the far side
`timescale 1ns/10ps
module test_dpm_host;
   import dpm_pkg::*;
   // ----------------------------------------------------------------
   // signals, instances, tasks
   // ----------------------------------------------------------------
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [7:0] s_awaddr = '0, s_araddr = '0;
   logic s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
   logic [31:0] s_wdata = '0, s_rdata, s, e, a;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, ce_n, rw_n, oe_n;
   logic [1:0] s_bresp, s_rresp, r;
   logic [14:0] mem_addr;
   logic [15:0] dq_i, dq_o, far_data = '0;
   logic token_select_n, int_n, busy_n, far_busy = 0, far_post = 0, far_int;
   logic [7:0] far_req = '0;
   int fail_count = 0, check_count = 0, seed = 88;
   dpm_host DUT (.aclk, .aresetn, .s_awaddr, .s_awprot(3'h0), .s_awvalid, .s_awready,
      .s_wdata, .s_wstrb(4'hf), .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
      .s_araddr, .s_arprot(3'h0), .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
      .s_rready, .mem_addr, .ce_n, .rw_n, .oe_n, .token_select_n, .ub_n(), .lb_n(),
      .dq_i, .dq_o, .dq_oe_n(), .int_n, .busy_n);
   dpm_dev_model u_dev (.mem_addr, .ce_n, .rw_n, .oe_n, .token_select_n, .dq_o, .dq_i,
      .int_n, .busy_n, .far_busy, .far_post, .far_data, .far_req, .far_int);
   initial forever #10 aclk = ~aclk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      @(posedge aclk);
      s_awaddr <= ad;
      s_wdata <= d;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_awready) s_awvalid <= 1'b0;
         if (s_wready) s_wvalid <= 1'b0;
      end while (!s_bvalid);
      s_bready <= 1'b0;
      r = s_bresp;
   endtask : wr
   task automatic rd(input logic [7:0] ad, output logic [31:0] d);
      @(posedge aclk);
      s_araddr <= ad;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_arready) s_arvalid <= 1'b0;
      end while (!s_rvalid);
      s_rready <= 1'b0;
      d = s_rdata;
      r = s_rresp;
   endtask : rd
   task automatic idle();
      do rd(REG_STATUS, s); while (s[ST_RUN] !== 1'b0);
   endtask : idle
   task automatic op(input logic [2:0] c, input logic [31:0] ad, input logic [31:0] d,
                     input bit done);
      wr(REG_ADDR, ad);
      wr(REG_WDATA, d);
      wr(REG_CTRL, {29'h0, c});
      if (done) idle();
   endtask : op
   task automatic rdata(input logic [31:0] exp);
      rd(REG_RDATA, s);
      chk(s, exp);
   endtask : rdata
   function automatic logic [31:0] sem_val(input bit own);
      return own ? 32'h0 : 32'h0000ffff;
   endfunction : sem_val
   task automatic results();
      if (fail_count == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : results
   initial begin
      repeat (40000) @(posedge aclk);
      fail_count++;
      results();
   end
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd(REG_CTRL, s);
      chk(s, 32'h7);
      rd(REG_STATUS, s);
      chk(s, 32'h0);
      rd(8'h20, s);
      chk(32'(r), 32'(RESP_SLVERR));
      wr(REG_RDATA, 32'h1);
      chk(32'(r), 32'(RESP_SLVERR));
      for (int k = 0; k < 6; k++) begin
         a = $random(seed) & 32'h3fff;
         e = (k == 0) ? 32'hffff : $random(seed) & 32'hffff;
         op(3'h1, a, e, 1);
         op(3'h0, a, 0, 1);
         rdata(e);
      end
      for (int k = 0; k < 8; k++) begin
         op(3'h4, 32'h7ff8 | k, 0, 1);
         rd(REG_STATUS, s);
         chk(32'(s[ST_OWNED]), 1);
         far_req[k] <= 1'b1;
         op(3'h2, 32'h7ff8 | k, 0, 1);
         rdata(sem_val(1));
         op(3'h3, k, 32'h1, 1);
         op(3'h2, k, 0, 1);
         rdata(sem_val(0));
         far_req[k] <= 1'b0;
         op(3'h3, k, 32'hfffe, 1);
         op(3'h2, k, 0, 1);
         rdata(sem_val(1));
         op(3'h3, k, 32'h1, 1);
         op(3'h2, k, 0, 1);
         rdata(sem_val(0));
      end
      far_data <= 16'h5a3c;
      far_post <= 1'b1;
      @(posedge aclk);
      far_post <= 1'b0;
      far_busy <= 1'b1;
      op(3'h6, 0, 0, 1);
      rd(REG_STATUS, s);
      chk(32'(s[ST_INT]), 1);
      far_busy <= 1'b0;
      op(3'h6, 0, 0, 1);
      rdata(32'h5a3c);
      rd(REG_STATUS, s);
      chk(32'(s[ST_INT]), 0);
      far_busy <= 1'b1;
      op(3'h5, 0, 32'hc3, 0);
      repeat (20) @(posedge aclk);
      rd(REG_STATUS, s);
      chk(32'(s[ST_BUSY_SEEN]), 1);
      chk(32'(far_int), 0);
      far_busy <= 1'b0;
      idle();
      chk(32'(far_int), 1);
      op(3'h0, 32'h7fff, 0, 1);
      rdata(32'hc3);
      chk(32'(far_int), 1);
      op(3'h7, 0, 0, 1);
      rd(REG_STATUS, s);
      chk(32'(s[ST_BAD]), 1);
      results();
   end
endmodule : test_dpm_host
